// >>> design/astr_serial_top.sv
// Purpose: double-buffered asynchronous serial transmitter and receiver with idle detect
// Assumes: control bits held stable during transfers; strobes are one-cycle pulses
// Notes: flags clear by status read then data access, set beats clear
// How it works
// - data bits: 8, 7+parity, 9 or 8+parity by frame mode and parity enable
// - transmitter runs while enabled, buffer holds next byte during shifting
// - shifter drives the pin while enabled or still transmitting
// - open-drain select makes the pin wired-or for serial or port use
// - buffer-empty low while data waits, rewrite overwrites, sets on shifter load
// - writes with buffer-empty set but not armed by status read are dropped
// - complete flag set at end, cleared by armed write only, not when a preamble or break starts
// - rising enable queues one idle preamble after the current frame
// - send-break emits whole zero frames, then complete, then one mark bit
// - all frames sent with enable on: empty and complete set, pin marks
// - after disable pending frames finish, buffered byte dropped, pin returned
// - quick disable and re-enable sends a preamble then resumes or idles
// - empty and complete requests gated by their own enables
// - receiver works while enabled, buffer holds a byte while next shifts in
// - stop bit completes the frame, moving data to buffer and setting full
// - noise, parity and framing flags raised only at the buffer transfer
// - frame while full: overrun set, old data kept, no error flags
// - status read arms clearing, data read clears the armed receive flags
// - receive request follows buffer full, overrun shares it, other errors do not
// - idle detect on while receiver enabled: ones for a whole frame length set idle
// - idle type short counts ones anywhere, long only after a stop bit
// - idle request by its enable; idle rearms only after a received frame
// - baud from clk over 32 times a 13-bit divisor, zero stops it
// - receiver samples at sixteen times baud and resyncs on edges
// - start accepted on a fall after three samples of one
// - parity in data msb, even or odd by type, mismatch flags parity
`timescale 1ns/10ps
module astr_serial_top import astr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic rxd_pin,
	output logic txd_out,
	output logic txd_oe,
	input wire logic port_data_bit,
	input wire logic port_dir_bit,
	input wire logic [DIV_W-1:0] baud_divisor_field,
	input wire logic transmitter_enable_bit,
	input wire logic receiver_enable_bit,
	input wire logic frame_long_mode,
	input wire logic parity_enable_bit,
	input wire logic parity_type_bit,
	input wire logic idle_type_select,
	input wire logic open_drain_select,
	input wire logic send_break_bit,
	input wire logic tx_empty_irq_enable,
	input wire logic tx_complete_irq_enable,
	input wire logic rx_irq_enable,
	input wire logic idle_irq_enable,
	input wire logic status_rd,
	input wire logic data_rd,
	input wire logic data_wr,
	input wire logic [8:0] wr_data,
	output logic [8:0] rd_data,
	output logic [NFLAG-1:0] serial_status_word,
	output logic irq_req
);
	logic os_tick, baud_tick, rxd_s;
	logic [NFLAG-1:0] flag_q, flag_d, arm_q, arm_d, fset, fclr;
	logic [8:0] tbuf_q, tbuf_d, rbuf_q, rbuf_d;
	logic wr_ok, tx_load, tx_done, tx_drop;
	logic rx_done, rx_xfer, rx_ovr, rx_nf, rx_fe, rx_pf, idle_hit;
	logic [8:0] rx_data;
	logic [3:0] n_data, f_len;

	astr_baud u_baud (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.baud_divisor_field(baud_divisor_field),
		.os_tick(os_tick),
		.baud_tick(baud_tick)
	);

	astr_sync u_rx_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.async_in(rxd_pin),
		.sync_out(rxd_s)
	);

	assign n_data = astr_data_bits(frame_long_mode);
	assign f_len = astr_frame_len(frame_long_mode);

	// host side: flags, arming, buffers
	assign wr_ok = data_wr & (~flag_q[FL_TX_BUFFER_EMPTY_FLAG] | arm_q[FL_TX_BUFFER_EMPTY_FLAG]);

	always_comb begin
		fset = '0;
		fclr = '0;
		fset[FL_TX_BUFFER_EMPTY_FLAG] = tx_load | tx_drop;
		fset[FL_TC] = tx_done;
		fset[FL_RX_BUFFER_FULL_FLAG] = rx_xfer;
		fset[FL_OR] = rx_ovr;
		fset[FL_NF] = rx_xfer & rx_nf;
		fset[FL_FE] = rx_xfer & rx_fe;
		fset[FL_PF] = rx_xfer & rx_pf;
		fset[FL_IDLE] = idle_hit;
		if (data_rd) begin
			fclr = arm_q & RX_FLAGS;
		end
		if (wr_ok) begin
			fclr = fclr | (arm_q & TX_FLAGS);
		end
		flag_d = (flag_q & ~fclr) | fset;
		// any data access uses up the arming, so a stale status read cannot admit a later write
		arm_d = status_rd ? flag_q : ((data_rd | data_wr) ? '0 : arm_q);
		tbuf_d = wr_ok ? wr_data : tbuf_q;
		rbuf_d = rx_xfer ? rx_data : rbuf_q;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= FLAG_RST;
			arm_q <= '0;
			tbuf_q <= '0;
			rbuf_q <= '0;
		end else begin
			flag_q <= flag_d;
			arm_q <= arm_d;
			tbuf_q <= tbuf_d;
			rbuf_q <= rbuf_d;
		end
	end

	assign rd_data = rbuf_q;
	assign serial_status_word = flag_q;
	assign irq_req = (tx_empty_irq_enable & flag_q[FL_TX_BUFFER_EMPTY_FLAG])
		| (tx_complete_irq_enable & flag_q[FL_TC])
		| (rx_irq_enable & (flag_q[FL_RX_BUFFER_FULL_FLAG] | flag_q[FL_OR]))
		| (idle_irq_enable & flag_q[FL_IDLE]);

	// transmitter
	astr_tx_state_type tx_state_q, tx_state_d;
	logic [10:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_left_q, tx_left_d;
	logic tx_brk_q, tx_brk_d, pre_q, pre_d, te_q, tx_end;
	logic pin_out_q, pin_out_d, pin_oe_q, pin_oe_d, tx_val, tx_active;
	logic [8:0] tx_word;

	always_comb begin
		tx_word = tbuf_q;
		if (parity_enable_bit) begin
			tx_word[n_data - 4'h1] = astr_xor(tbuf_q, 4'(n_data - 4'h1)) ^ parity_type_bit;
		end
	end

	always_comb begin
		tx_state_d = tx_state_q;
		tx_sh_d = tx_sh_q;
		tx_left_d = tx_left_q;
		tx_brk_d = tx_brk_q;
		pre_d = (pre_q | (transmitter_enable_bit & ~te_q)) & transmitter_enable_bit;
		tx_load = 1'b0;
		tx_done = 1'b0;
		tx_drop = 1'b0;
		tx_end = 1'b0;
		case (tx_state_q)
			TX_IDLE: tx_end = baud_tick;
			TX_SHIFT: begin
				if (baud_tick) begin
					tx_sh_d = {1'b1, tx_sh_q[10:1]};
					tx_left_d = 4'(tx_left_q - 4'h1);
					tx_end = (tx_left_q == 4'h1);
				end
			end
			TX_MARK: begin
				// one mark bit after a break so the next start is seen
				if (baud_tick) begin
					tx_state_d = TX_IDLE;
				end
			end
			default: tx_state_d = TX_IDLE;
		endcase
		if (tx_end) begin
			tx_left_d = f_len;
			tx_brk_d = 1'b0;
			tx_state_d = TX_SHIFT;
			if (pre_d) begin
				pre_d = 1'b0;
				tx_sh_d = '1;
			end else if (send_break_bit & transmitter_enable_bit) begin
				tx_sh_d = '0;
				tx_brk_d = 1'b1;
			end else if (tx_brk_q) begin
				tx_state_d = TX_MARK;
				tx_done = 1'b1;
			end else if (transmitter_enable_bit & ~flag_q[FL_TX_BUFFER_EMPTY_FLAG]) begin
				tx_sh_d = frame_long_mode ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
				tx_load = 1'b1;
			end else begin
				tx_state_d = TX_IDLE;
				tx_done = (tx_state_q == TX_SHIFT);
				tx_drop = ~transmitter_enable_bit & ~flag_q[FL_TX_BUFFER_EMPTY_FLAG];
			end
		end
		tx_val = (tx_state_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
		tx_active = transmitter_enable_bit | (tx_state_q != TX_IDLE);
		pin_out_d = tx_active ? tx_val : port_data_bit;
		// open drain only ever pulls low; the pull-up gives the one
		pin_oe_d = (tx_active | port_dir_bit) & (~open_drain_select | ~pin_out_d);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_q <= TX_IDLE;
			tx_sh_q <= '1;
			tx_left_q <= '0;
			tx_brk_q <= 1'b0;
			pre_q <= 1'b0;
			te_q <= 1'b0;
			pin_out_q <= 1'b1;
			pin_oe_q <= 1'b0;
		end else begin
			tx_state_q <= tx_state_d;
			tx_sh_q <= tx_sh_d;
			tx_left_q <= tx_left_d;
			tx_brk_q <= tx_brk_d;
			pre_q <= pre_d;
			te_q <= transmitter_enable_bit;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign txd_out = pin_out_q;
	assign txd_oe = pin_oe_q;

	// receiver
	astr_rx_state_type rx_state_q, rx_state_d;
	logic [3:0] ph_q, ph_d, idx_q, idx_d;
	logic [1:0] smp_q, smp_d, run_q, run_d;
	logic [8:0] rsh_q, rsh_d;
	logic nacc_q, nacc_d, prev_q, rx_bit, rx_noisy, start_ok, wrap;

	assign start_ok = receiver_enable_bit & os_tick & ~rxd_s & (run_q == START_ONES);

	always_comb begin
		rx_state_d = rx_state_q;
		ph_d = ph_q;
		idx_d = idx_q;
		smp_d = smp_q;
		rsh_d = rsh_q;
		nacc_d = nacc_q;
		run_d = run_q;
		rx_done = 1'b0;
		rx_fe = 1'b0;
		rx_bit = (smp_q[0] & smp_q[1]) | (smp_q[0] & rxd_s) | (smp_q[1] & rxd_s);
		rx_noisy = ~((smp_q[0] == smp_q[1]) & (smp_q[1] == rxd_s));
		wrap = 1'b0;
		if (os_tick) begin
			run_d = ~rxd_s ? 2'h0 : ((run_q == START_ONES) ? run_q : 2'(run_q + 2'h1));
		end
		case (rx_state_q)
			RX_WAIT: begin
				if (start_ok) begin
					rx_state_d = RX_BITS;
					ph_d = '0;
					idx_d = '0;
					nacc_d = 1'b0;
				end
			end
			RX_BITS: begin
				if (os_tick) begin
					// an edge late in the bit marks the next boundary early
					wrap = (ph_q == OS_LAST) | ((rxd_s ^ prev_q) & (ph_q >= RESYNC_LO));
					ph_d = wrap ? 4'h0 : 4'(ph_q + 4'h1);
					idx_d = wrap ? 4'(idx_q + 4'h1) : idx_q;
					if (ph_q == SAMP_A) begin
						smp_d[0] = rxd_s;
					end
					if (ph_q == SAMP_B) begin
						smp_d[1] = rxd_s;
					end
					if (ph_q == SAMP_C) begin
						nacc_d = nacc_q | rx_noisy;
						if (idx_q == 4'h0) begin
							rx_state_d = rx_bit ? RX_WAIT : RX_BITS;
						end else if (idx_q <= n_data) begin
							rsh_d = {rx_bit, rsh_q[8:1]};
						end else begin
							rx_done = 1'b1;
							rx_fe = ~rx_bit;
							rx_state_d = RX_WAIT;
						end
					end
				end
			end
			default: rx_state_d = RX_WAIT;
		endcase
		if (~receiver_enable_bit) begin
			rx_state_d = RX_WAIT;
		end
		rx_nf = nacc_d;
		rx_data = frame_long_mode ? rsh_q : {1'b0, rsh_q[8:1]};
		rx_pf = parity_enable_bit & (astr_xor(rx_data, n_data) ^ parity_type_bit);
		rx_xfer = rx_done & ~flag_q[FL_RX_BUFFER_FULL_FLAG];
		rx_ovr = rx_done & flag_q[FL_RX_BUFFER_FULL_FLAG];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_q <= RX_WAIT;
			ph_q <= '0;
			idx_q <= '0;
			smp_q <= '0;
			rsh_q <= '0;
			nacc_q <= 1'b0;
			run_q <= '0;
			prev_q <= 1'b1;
		end else begin
			rx_state_q <= rx_state_d;
			ph_q <= ph_d;
			idx_q <= idx_d;
			smp_q <= smp_d;
			rsh_q <= rsh_d;
			nacc_q <= nacc_d;
			run_q <= run_d;
			prev_q <= os_tick ? rxd_s : prev_q;
		end
	end

	// idle line detection
	logic [3:0] icnt_q, icnt_d;
	logic after_stop_q, after_stop_d, idle_ok_q, idle_ok_d;

	always_comb begin
		icnt_d = icnt_q;
		after_stop_d = after_stop_q | rx_done;
		if (baud_tick) begin
			if (~rxd_s) begin
				icnt_d = '0;
				after_stop_d = 1'b0;
			end else if ((~idle_type_select | after_stop_q) & (icnt_q < f_len)) begin
				icnt_d = 4'(icnt_q + 4'h1);
			end
		end
		idle_hit = receiver_enable_bit & idle_ok_q & (icnt_d == f_len) & (icnt_q != f_len);
		idle_ok_d = (idle_ok_q & ~idle_hit) | rx_xfer;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			icnt_q <= '0;
			after_stop_q <= 1'b0;
			idle_ok_q <= 1'b1;
		end else begin
			icnt_q <= icnt_d;
			after_stop_q <= after_stop_d;
			idle_ok_q <= idle_ok_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_tc_set_end: assert property (tx_done |=> flag_q[FL_TC])
		else $error("complete flag not set after shifting ended");
	a_break_zero: assert property ((tx_state_q == TX_SHIFT) && tx_brk_q |-> ##1 !pin_out_q)
		else $error("break frame bit not zero on pin");
	a_mark_hold: assert property ((tx_state_q == TX_IDLE) && transmitter_enable_bit && te_q |=> pin_out_q)
		else $error("idle transmitter not marking");
	a_od_release: assert property (open_drain_select && pin_oe_q |-> !pin_out_q)
		else $error("open drain pin driven high");
	a_wr_ignore: assert property (data_wr && flag_q[FL_TX_BUFFER_EMPTY_FLAG] && !arm_q[FL_TX_BUFFER_EMPTY_FLAG] |=> $stable(tbuf_q))
		else $error("unarmed write reached the buffer");
	a_ovr_keep: assert property (rx_done && flag_q[FL_RX_BUFFER_FULL_FLAG] |=> $stable(rbuf_q) && flag_q[FL_OR])
		else $error("overrun lost old data or flag");
	a_rx_xfer: assert property (rx_xfer |=> flag_q[FL_RX_BUFFER_FULL_FLAG] && (rbuf_q == $past(rx_data)))
		else $error("frame not moved to receive buffer");
	a_start_guard: assert property ((rx_state_q == RX_WAIT) ##1 (rx_state_q == RX_BITS) |-> $past(run_q) == START_ONES)
		else $error("start taken without three ones");
	a_idle_once: assert property ($rose(flag_q[FL_IDLE]) |-> $past(idle_ok_q))
		else $error("idle flag rearmed without a frame");
	a_baud_stop: assert property ((baud_divisor_field == '0) [*2] |-> !os_tick)
		else $error("baud generator runs with zero divisor");
endmodule // astr_serial_top

// >>> design/astr_pkg.sv
// Purpose: shared constants, types and helpers of the serial transmitter/receiver
// Assumes: one system clock, all control bits supplied as plain ports
// Notes: frame lengths count start and stop bits
package astr_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int DIV_W = 13;
	localparam int OS_W = 4;
	localparam logic [OS_W-1:0] OS_LAST = 4'hf;
	localparam logic [3:0] SAMP_A = 4'h7;
	localparam logic [3:0] SAMP_B = 4'h8;
	localparam logic [3:0] SAMP_C = 4'h9;
	localparam logic [3:0] RESYNC_LO = 4'hc;
	localparam logic [1:0] START_ONES = 2'h3;
	localparam logic [3:0] DATA_SHORT = 4'h8;
	localparam logic [3:0] DATA_LONG = 4'h9;
	localparam logic [3:0] LEN_SHORT = 4'ha;
	localparam logic [3:0] LEN_LONG = 4'hb;
	localparam int NFLAG = 8;
	localparam int FL_TX_BUFFER_EMPTY_FLAG = 0;
	localparam int FL_TC = 1;
	localparam int FL_RX_BUFFER_FULL_FLAG = 2;
	localparam int FL_IDLE = 3;
	localparam int FL_OR = 4;
	localparam int FL_NF = 5;
	localparam int FL_FE = 6;
	localparam int FL_PF = 7;
	localparam logic [NFLAG-1:0] FLAG_RST = 8'h03;
	localparam logic [NFLAG-1:0] TX_FLAGS = 8'h03;
	localparam logic [NFLAG-1:0] RX_FLAGS = 8'hfc;

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_MARK = 2'b11} astr_tx_state_type;
	typedef enum logic {RX_WAIT = 1'b0, RX_BITS = 1'b1} astr_rx_state_type;

	function automatic logic [3:0] astr_data_bits(input logic long_mode);
		return long_mode ? DATA_LONG : DATA_SHORT;
	endfunction

	function automatic logic [3:0] astr_frame_len(input logic long_mode);
		return long_mode ? LEN_LONG : LEN_SHORT;
	endfunction

	// xor of the lowest n bits
	function automatic logic astr_xor(input logic [8:0] d, input logic [3:0] n);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				r = r ^ d[i];
			end
		end
		return r;
	endfunction
endpackage

// >>> design/astr_sync.sv
// Purpose: two-stage synchroniser for the receive pin
// Assumes: input is asynchronous to clk_sys
// Notes: resets to mark so a quiet line reads as idle
`timescale 1ns/10ps
module astr_sync (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // astr_sync

// >>> design/astr_baud.sv
// Purpose: modulus divider making the oversample tick and the baud tick
// Assumes: oversample rate is sixteen times the baud rate
// Notes: a zero divisor holds both ticks low
`timescale 1ns/10ps
module astr_baud import astr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [DIV_W-1:0] baud_divisor_field,
	output logic os_tick,
	output logic baud_tick
);
	logic [DIV_W:0] cnt_q, cnt_d;
	logic [OS_W-1:0] os_q, os_d;
	logic os_tick_q, os_tick_d, baud_tick_q, baud_tick_d;

	always_comb begin
		cnt_d = cnt_q;
		os_d = os_q;
		os_tick_d = 1'b0;
		baud_tick_d = 1'b0;
		if (baud_divisor_field == '0) begin
			cnt_d = '0;
		end else if (cnt_q == '0) begin
			// two clocks per divisor unit gives clk / (32 * div) per bit
			cnt_d = (DIV_W+1)'({baud_divisor_field, 1'b0} - 14'h0001);
			os_tick_d = 1'b1;
			os_d = OS_W'(os_q + 4'h1);
			baud_tick_d = (os_q == OS_LAST);
		end else begin
			cnt_d = (DIV_W+1)'(cnt_q - 14'h0001);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			os_q <= '0;
			os_tick_q <= 1'b0;
			baud_tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			os_q <= os_d;
			os_tick_q <= os_tick_d;
			baud_tick_q <= baud_tick_d;
		end
	end

	assign os_tick = os_tick_q;
	assign baud_tick = baud_tick_q;
endmodule // astr_baud

// >>> bench/astr_peer.sv
// Purpose: far-side serial device, sends frames to rxd and captures txd frames
// Assumes: same bit time as the design, one stop bit
// Notes: line marks between frames; captured frame holds start..stop bits
`timescale 1ns/10ps
module astr_peer #(parameter int BIT_CLKS = 32) (
	input wire logic clk_sys,
	input wire logic send,
	input wire logic [10:0] send_frame,
	input wire logic [3:0] send_len,
	input wire logic line_in,
	input wire logic [3:0] cap_len,
	output logic line_out,
	output logic [10:0] got_frame,
	output int got_cnt
);
	initial begin
		line_out = 1'b1;
		got_frame = '0;
		got_cnt = 0;
	end
	// bit 0 leaves first
	always begin : drive_frame
		@(posedge clk_sys iff send);
		for (int i = 0; i < send_len; i++) begin
			@(negedge clk_sys);
			line_out = send_frame[i];
			repeat (BIT_CLKS - 1) @(negedge clk_sys);
		end
		@(negedge clk_sys);
		line_out = 1'b1;
	end
	// mid-bit capture, first bit is the start bit
	always begin : catch_frame
		logic [10:0] f;
		@(negedge line_in);
		f = '0;
		repeat (BIT_CLKS / 2) @(posedge clk_sys);
		for (int i = 0; i < 11; i++) begin
			if (i < cap_len) f[i] = line_in;
			if (i < cap_len - 1) repeat (BIT_CLKS) @(posedge clk_sys);
		end
		got_frame = f;
		got_cnt = got_cnt + 1;
	end
endmodule // astr_peer

// >>> bench/astr_serial_top_test.sv
// Purpose: self-checking bench of the serial transmitter/receiver
// Assumes: divisor 1, so one bit is 32 clocks
// Notes: txd has a pull-up when not driven
`timescale 1ns/10ps
module astr_serial_top_test import astr_pkg::*; ;
	typedef struct {logic lng, pe, pt; logic [8:0] pay; logic pf; logic [10:0] txf;} astr_row_type;
	astr_row_type rows [6] = '{'{0,0,0,9'h0a5,0,11'h34a}, '{0,1,0,9'h055,0,11'h2aa},
		'{0,1,1,9'h003,1,11'h306}, '{1,0,0,9'h1c3,0,11'h786},
		'{1,1,1,9'h0f0,1,11'h7e0}, '{1,1,0,9'h1f1,0,11'h7e2}};
	logic clk_sys, rst_b, rxd_pin, txd_out, txd_oe, port_data_bit, port_dir_bit;
	logic [DIV_W-1:0] baud_divisor_field;
	logic transmitter_enable_bit, receiver_enable_bit, frame_long_mode, parity_enable_bit, parity_type_bit;
	logic idle_type_select, open_drain_select, send_break_bit, tx_empty_irq_enable, tx_complete_irq_enable;
	logic rx_irq_enable, idle_irq_enable, status_rd, data_rd, data_wr, irq_req, send;
	logic [8:0] wr_data, rd_data;
	logic [NFLAG-1:0] serial_status_word;
	logic [10:0] send_frame, got_frame;
	logic [3:0] send_len;
	int got_cnt, bad_count, tests_run, cyc, prev;
	wire txd_line = txd_oe ? txd_out : 1'b1;
	wire [3:0] cap_len = frame_long_mode ? 4'hb : 4'ha;

	astr_serial_top astr_serial_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .rxd_pin(rxd_pin),
		.txd_out(txd_out), .txd_oe(txd_oe), .port_data_bit(port_data_bit), .port_dir_bit(port_dir_bit),
		.baud_divisor_field(baud_divisor_field), .transmitter_enable_bit(transmitter_enable_bit),
		.receiver_enable_bit(receiver_enable_bit), .frame_long_mode(frame_long_mode),
		.parity_enable_bit(parity_enable_bit), .parity_type_bit(parity_type_bit),
		.idle_type_select(idle_type_select), .open_drain_select(open_drain_select),
		.send_break_bit(send_break_bit), .tx_empty_irq_enable(tx_empty_irq_enable),
		.tx_complete_irq_enable(tx_complete_irq_enable), .rx_irq_enable(rx_irq_enable),
		.idle_irq_enable(idle_irq_enable), .status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr),
		.wr_data(wr_data), .rd_data(rd_data), .serial_status_word(serial_status_word), .irq_req(irq_req));
	astr_peer astr_peer_inst (.clk_sys(clk_sys), .send(send), .send_frame(send_frame), .send_len(send_len),
		.line_in(txd_line), .cap_len(cap_len), .line_out(rxd_pin), .got_frame(got_frame), .got_cnt(got_cnt));

	always #4 clk_sys = ~clk_sys;
	// whole run needs about 9000 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_val(input string nm, input logic [10:0] exp, input logic [10:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_flag(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// one-cycle host strobe
	task automatic host(input logic s, input logic r, input logic w, input logic [8:0] d);
		@(negedge clk_sys);
		status_rd = s;
		data_rd = r;
		data_wr = w;
		wr_data = d;
		@(negedge clk_sys);
		{status_rd, data_rd, data_wr} = 3'b000;
	endtask
	task automatic wait_flag(input int idx);
		int i;
		i = 0;
		while (serial_status_word[idx] !== 1'b1 && i < 3000) begin
			tick(1);
			i++;
		end
		if (i == 3000) chk_val("flag_wait", 11'(idx), 11'h7ff);
	endtask
	task automatic wait_got(input int p);
		int i;
		i = 0;
		while (got_cnt == p && i < 3000) begin
			tick(1);
			i++;
		end
		if (i == 3000) chk_val("peer_wait", 11'h1, 11'h0);
	endtask
	task automatic rx_frame(input logic [10:0] f, input logic [3:0] len);
		// let the peer finish the stop bit of the previous frame, or the send pulse is missed
		tick(32);
		send_frame = f;
		send_len = len;
		send = 1'b1;
		tick(1);
		send = 1'b0;
		wait_flag(FL_RX_BUFFER_FULL_FLAG);
	endtask

	initial begin
		clk_sys = 0;
		rst_b = 0;
		{port_data_bit, port_dir_bit, transmitter_enable_bit, receiver_enable_bit} = '0;
		{frame_long_mode, parity_enable_bit, parity_type_bit, idle_type_select, open_drain_select} = '0;
		{send_break_bit, tx_empty_irq_enable, tx_complete_irq_enable, rx_irq_enable, idle_irq_enable} = '0;
		{status_rd, data_rd, data_wr, send} = '0;
		wr_data = '0;
		send_frame = '0;
		send_len = '0;
		baud_divisor_field = 13'h0001;
		bad_count = 0;
		tests_run = 0;
		cyc = 0;
		tick(4);
		chk_flag("reset_flags", 8'h03, serial_status_word);
		chk_val("reset_oe", 11'h0, 11'(txd_oe));
		rst_b = 1;
		{transmitter_enable_bit, receiver_enable_bit} = 2'b11;
		tick(400);
		foreach (rows[k]) begin
			{frame_long_mode, parity_enable_bit, parity_type_bit} = {rows[k].lng, rows[k].pe, rows[k].pt};
			rx_frame({2'b01, rows[k].pay} << 1 | (11'h2 << (rows[k].lng ? 9 : 8)), cap_len);
			tick(2);
			chk_val("rx_data", 11'(rows[k].pay), 11'(rd_data));
			chk_flag("rx_flags", {rows[k].pf, 7'h04}, serial_status_word & 8'hf4);
			host(1, 0, 0, 0);
			host(0, 1, 0, 0);
			chk_flag("rx_clear", 8'h00, serial_status_word & 8'hf4);
			prev = got_cnt;
			host(1, 0, 0, 0);
			host(0, 0, 1, rows[k].pay);
			wait_got(prev);
			chk_val("tx_frame", rows[k].txf, got_frame);
			wait_flag(FL_TC);
			chk_flag("tx_done", 8'h03, serial_status_word & 8'h03);
			chk_val("tx_mark", 11'h1, 11'(txd_line));
		end
		{frame_long_mode, parity_enable_bit, rx_irq_enable} = 3'b001;
		rx_frame(11'h222, 4'ha);
		rx_frame(11'h244, 4'ha);
		wait_flag(FL_OR);
		tick(2);
		chk_val("ovr_data", 11'h011, 11'(rd_data));
		chk_flag("ovr_flags", 8'h14, serial_status_word & 8'hf4);
		chk_val("rx_irq", 11'h1, 11'(irq_req));
		host(1, 0, 0, 0);
		host(0, 1, 0, 0);
		chk_val("rx_irq_off", 11'h0, 11'(irq_req));
		rx_frame(11'h0b4, 4'ha);
		tick(2);
		chk_flag("frame_err", 8'h44, serial_status_word & 8'hf4);
		host(1, 0, 0, 0);
		host(0, 1, 0, 0);
		wait_flag(FL_IDLE);
		idle_irq_enable = 1;
		tick(1);
		chk_val("idle_irq", 11'h1, 11'(irq_req));
		host(1, 0, 0, 0);
		host(0, 1, 0, 0);
		tick(480);
		chk_val("idle_once", 11'h0, 11'(serial_status_word[FL_IDLE]));
		idle_irq_enable = 0;
		prev = got_cnt;
		host(0, 0, 1, 9'h0ff);
		tick(480);
		chk_val("unarmed_wr", 11'(prev), 11'(got_cnt));
		tx_empty_irq_enable = 1;
		tick(1);
		chk_val("empty_irq", 11'h1, 11'(irq_req));
		{tx_empty_irq_enable, tx_complete_irq_enable} = 2'b01;
		tick(1);
		chk_val("done_irq", 11'h1, 11'(irq_req));
		tx_complete_irq_enable = 0;
		prev = got_cnt;
		send_break_bit = 1;
		wait_got(prev);
		send_break_bit = 0;
		chk_val("break", 11'h0, got_frame);
		tick(700);
		chk_val("break_mark", 11'h1, 11'(txd_line));
		{port_dir_bit, port_data_bit} = 2'b10;
		prev = got_cnt;
		host(1, 0, 0, 0);
		host(0, 0, 1, 9'h03c);
		tick(2);
		wait_flag(FL_TX_BUFFER_EMPTY_FLAG);
		// disable while the shifter still holds the byte
		transmitter_enable_bit = 0;
		wait_got(prev);
		chk_val("drain", 11'h278, got_frame);
		wait_flag(FL_TC);
		tick(40);
		chk_val("port_oe", 11'h1, 11'(txd_oe));
		chk_val("port_val", 11'h0, 11'(txd_out));
		{open_drain_select, port_data_bit} = 2'b11;
		tick(4);
		chk_val("od_release", 11'h0, 11'(txd_oe));
		end_sim();
	end
endmodule // astr_serial_top_test
